// ===== sadf_regs.vh
`ifndef SADF_REGS_VH
`define SADF_REGS_VH
`define SADF_CTRL_OFS 5'h00
`define SADF_STAT_OFS 5'h04
`define SADF_DFLT_OFS 5'h08
`define SADF_LDAT_OFS 5'h0c
`define SADF_RDAT_OFS 5'h10
`define SADF_CTRL_RST 16'h0005
`define SADF_CTRL_MASK 16'hb17f
`define SADF_STAT_WMASK 16'ha4a4
`define SADF_EN_BIT 15
`define SADF_SIDL_BIT 13
`define SADF_AMPLIFIER_KEEP_ON_BIT 12
`define SADF_DATA_FORMAT_SELECT_BIT 8
`define SADF_DIV_W 7
`define SADF_OEN_BIT 7
`define SADF_MVOEN_BIT 5
`define SADF_ITYPE_BIT 2
`define SADF_FULL_BIT 1
`define SADF_EMPTY_BIT 0
`define SADF_CH_STRIDE 8
`define SADF_OSR_W 8
`define SADF_FIFO_DEPTH 4
`define SADF_RESP_OKAY 2'b00
`define SADF_RESP_SLVERR 2'b10
`endif

// ===== sadf_fifo.v
`timescale 1ns/1ps
module sadf_fifo #(
   parameter W = 16,
   parameter D = 4,
   parameter AW = 2
)(
   // clock and reset
   input wire ref_clk_i,
   input wire rstn_i,
   // control
   input wire flush_i,
   // write side
   input wire wr_i,
   input wire [W-1:0] wdata_i,
   // read side
   input wire rd_i,
   output wire [W-1:0] rdata_o,
   // state
   output wire full_o,
   output wire empty_o
);
   reg [W-1:0] mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;
   integer i;

   assign full_o = (cnt_q == D[AW:0]);
   assign empty_o = (cnt_q == {(AW+1){1'b0}});
   assign do_wr = wr_i & ~full_o;
   assign do_rd = rd_i & ~empty_o;
   assign rdata_o = mem_q[rp_q];

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (i = 0; i < D; i = i + 1)
            mem_q[i] <= {W{1'b0}};
      end
      else if (flush_i)
      begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            mem_q[wp_q] <= wdata_i;
            wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (do_rd)
            rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         if (do_wr & ~do_rd)
            cnt_q <= cnt_q + 1'b1;
         else if (do_rd & ~do_wr)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// ===== sadf_top.v
`timescale 1ns/1ps
`include "sadf_regs.vh"
module sadf_top #(
   parameter DEPTH = `SADF_FIFO_DEPTH,
   parameter INT_W = 24
)(
   // clock and reset
   input wire ref_clk_i,
   input wire rstn_i,
   // power state
   input wire idle_i,
   input wire sleep_i,
   // axi4-lite write address
   input wire awvalid_i,
   output wire awready_o,
   input wire [31:0] awaddr_i,
   input wire [2:0] awprot_i,
   // axi4-lite write data
   input wire wvalid_i,
   output wire wready_o,
   input wire [31:0] wdata_i,
   input wire [3:0] wstrb_i,
   // axi4-lite write response
   output wire bvalid_o,
   input wire bready_i,
   output wire [1:0] bresp_o,
   // axi4-lite read address
   input wire arvalid_i,
   output wire arready_o,
   input wire [31:0] araddr_i,
   input wire [2:0] arprot_i,
   // axi4-lite read data
   output wire rvalid_o,
   input wire rready_i,
   output wire [31:0] rdata_o,
   output wire [1:0] rresp_o,
   // converter outputs, index 0 right, 1 left
   output wire [1:0] pos_o,
   output wire [1:0] neg_o,
   output wire [1:0] mid_en_o,
   output wire [1:0] buf_req_o,
   output wire amp_en_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // register state
   reg [15:0] ctrl_q;
   reg [15:0] stat_q;
   reg [15:0] dflt_q;
   reg [15:0] ldat_q;
   reg [15:0] rdat_q;
   reg aw_full_q;
   reg w_full_q;
   reg [4:0] aw_addr_q;
   reg aw_bad_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg awrdy_q;
   reg wrdy_q;
   reg arrdy_q;
   reg amp_q;
   reg [`SADF_DIV_W-1:0] div_cnt_q;
   reg [`SADF_OSR_W-1:0] phase_q;
   wire [1:0] full_w;
   wire [1:0] empty_w;
   wire [1:0] push_w;
   wire [15:0] wr_val;
   wire do_write;
   wire enable;
   wire halted;
   wire run;
   wire tick;
   wire take;

   assign enable = ctrl_q[`SADF_EN_BIT];
   assign halted = ~enable | sleep_i | (idle_i & ctrl_q[`SADF_SIDL_BIT]);
   assign run = ~halted;
   assign tick = run & (div_cnt_q == ctrl_q[`SADF_DIV_W-1:0]);
   assign take = tick & (phase_q == {`SADF_OSR_W{1'b1}});
   assign do_write = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_val = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                    w_strb_q[0] ? w_data_q[7:0] : 8'h00};

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   assign awready_o = awrdy_q;
   assign wready_o = wrdy_q;
   assign bvalid_o = bvalid_q;
   assign bresp_o = bresp_q;
   assign arready_o = arrdy_q;
   assign rvalid_o = rvalid_q;
   assign rdata_o = rdata_q;
   assign rresp_o = rresp_q;

   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [3:0] strb;
      begin
         merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   function is_bad;
      input [31:0] a;
      begin
         is_bad = (a[31:5] != 27'h0000000) | (a[1:0] != 2'b00) |
                  (a[4:0] > `SADF_RDAT_OFS);
      end
   endfunction

   assign push_w[1] = do_write & ~aw_bad_q & (aw_addr_q == `SADF_LDAT_OFS) &
                      (w_strb_q[1:0] != 2'b00);
   assign push_w[0] = do_write & ~aw_bad_q & (aw_addr_q == `SADF_RDAT_OFS) &
                      (w_strb_q[1:0] != 2'b00);

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         aw_addr_q <= 5'h00;
         aw_bad_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `SADF_RESP_OKAY;
         ctrl_q <= `SADF_CTRL_RST;
         stat_q <= 16'h0000;
         dflt_q <= 16'h0000;
         ldat_q <= 16'h0000;
         rdat_q <= 16'h0000;
      end
      else
      begin
         if (awvalid_i & ~aw_full_q)
         begin
            aw_full_q <= 1'b1;
            awrdy_q <= 1'b0;
            aw_addr_q <= awaddr_i[4:0];
            aw_bad_q <= is_bad(awaddr_i);
         end
         if (wvalid_i & ~w_full_q)
         begin
            w_full_q <= 1'b1;
            wrdy_q <= 1'b0;
            w_data_q <= wdata_i;
            w_strb_q <= wstrb_i;
         end
         if (bvalid_q & bready_i)
            bvalid_q <= 1'b0;
         if (do_write)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            bvalid_q <= 1'b1;
            bresp_q <= aw_bad_q ? `SADF_RESP_SLVERR : `SADF_RESP_OKAY;
            if (!aw_bad_q)
            begin
               case (aw_addr_q)
                  `SADF_CTRL_OFS: ctrl_q <= merge(ctrl_q, wr_val, w_strb_q) &
                                            `SADF_CTRL_MASK;
                  `SADF_STAT_OFS: stat_q <= merge(stat_q, wr_val, w_strb_q) &
                                            `SADF_STAT_WMASK;
                  `SADF_DFLT_OFS: dflt_q <= merge(dflt_q, wr_val, w_strb_q);
                  `SADF_LDAT_OFS: ldat_q <= merge(ldat_q, wr_val, w_strb_q);
                  `SADF_RDAT_OFS: rdat_q <= merge(rdat_q, wr_val, w_strb_q);
                  default: ctrl_q <= ctrl_q;
               endcase
            end
         end
      end
   end

   // status view: writable enables and live buffer state
   function [15:0] stat_view;
      input [15:0] s;
      input [1:0] f;
      input [1:0] e;
      begin
         stat_view = s;
         stat_view[`SADF_CH_STRIDE + `SADF_FULL_BIT] = f[1];
         stat_view[`SADF_CH_STRIDE + `SADF_EMPTY_BIT] = e[1];
         stat_view[`SADF_FULL_BIT] = f[0];
         stat_view[`SADF_EMPTY_BIT] = e[0];
      end
   endfunction

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rvalid_q <= 1'b0;
         arrdy_q <= 1'b1;
         rdata_q <= 32'h00000000;
         rresp_q <= `SADF_RESP_OKAY;
      end
      else if (rvalid_q)
      begin
         if (rready_i)
         begin
            rvalid_q <= 1'b0;
            arrdy_q <= 1'b1;
         end
      end
      else if (arvalid_i)
      begin
         rvalid_q <= 1'b1;
         arrdy_q <= 1'b0;
         rresp_q <= is_bad(araddr_i) ? `SADF_RESP_SLVERR : `SADF_RESP_OKAY;
         case (is_bad(araddr_i) ? 5'h1f : araddr_i[4:0])
            `SADF_CTRL_OFS: rdata_q <= {16'h0000, ctrl_q};
            `SADF_STAT_OFS: rdata_q <= {16'h0000, stat_view(stat_q, full_w, empty_w)};
            `SADF_DFLT_OFS: rdata_q <= {16'h0000, dflt_q};
            `SADF_LDAT_OFS: rdata_q <= {16'h0000, ldat_q};
            `SADF_RDAT_OFS: rdata_q <= {16'h0000, rdat_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // converter clock divider and sample pacing
   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         div_cnt_q <= {`SADF_DIV_W{1'b0}};
         phase_q <= {`SADF_OSR_W{1'b0}};
         amp_q <= 1'b0;
      end
      else
      begin
         amp_q <= enable & (run | ctrl_q[`SADF_AMPLIFIER_KEEP_ON_BIT]);
         if (!enable)
         begin
            div_cnt_q <= {`SADF_DIV_W{1'b0}};
            phase_q <= {`SADF_OSR_W{1'b0}};
         end
         else if (run)
         begin
            div_cnt_q <= tick ? {`SADF_DIV_W{1'b0}} : div_cnt_q + 1'b1;
            if (tick)
               phase_q <= phase_q + 1'b1;
         end
      end
   end
   assign amp_en_o = amp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel buffer, interpolator and modulator
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1)
      begin : g_ch
         wire [15:0] head;
         wire [15:0] raw;
         wire [16:0] diff;
         wire [25:0] prod;
         wire [16:0] interp;
         wire [INT_W-1:0] x;
         wire [INT_W-1:0] fb;
         wire [INT_W-1:0] i1_d;
         wire [INT_W-1:0] i2_d;
         reg [15:0] prev_q;
         reg [15:0] cur_q;
         reg [INT_W-1:0] i1_q;
         reg [INT_W-1:0] i2_q;
         reg bit_q;
         reg pos_q;
         reg neg_q;
         reg mid_q;
         reg req_q;

         sadf_fifo #(
            .W(16),
            .D(DEPTH),
            .AW(2)
         ) u_fifo (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .flush_i(~enable),
            .wr_i(push_w[c]),
            .wdata_i(wr_val),
            .rd_i(take),
            .rdata_o(head),
            .full_o(full_w[c]),
            .empty_o(empty_w[c])
         );

         assign raw = empty_w[c] ? dflt_q : head;
         // offset-binary to two's complement; signed passes through
         assign diff = {cur_q[15], cur_q} - {prev_q[15], prev_q};
         assign prod = $signed(diff) * $signed({1'b0, phase_q});
         assign interp = {prev_q[15], prev_q} + prod[24:8];
         assign x = {{(INT_W-17){interp[16]}}, interp};
         assign fb = bit_q ? {{(INT_W-16){1'b0}}, 16'h7fff} : {{(INT_W-16){1'b1}}, 16'h8000};
         assign i1_d = i1_q + x - fb;
         // unity feedback on both stages keeps the loop shaping (1-z^-1)^2
         assign i2_d = i2_q + i1_d - fb;

         always @(posedge ref_clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               prev_q <= 16'h0000;
               cur_q <= 16'h0000;
               i1_q <= {INT_W{1'b0}};
               i2_q <= {INT_W{1'b0}};
               bit_q <= 1'b0;
               pos_q <= 1'b0;
               neg_q <= 1'b0;
               mid_q <= 1'b0;
               req_q <= 1'b0;
            end
            else
            begin
               if (take)
               begin
                  prev_q <= cur_q;
                  cur_q <= ctrl_q[`SADF_DATA_FORMAT_SELECT_BIT] ? raw : {~raw[15], raw[14:0]};
               end
               if (!enable)
               begin
                  i1_q <= {INT_W{1'b0}};
                  i2_q <= {INT_W{1'b0}};
               end
               else if (tick)
               begin
                  i1_q <= i1_d;
                  i2_q <= i2_d;
                  bit_q <= ~i2_d[INT_W-1];
               end
               pos_q <= enable & stat_q[c*`SADF_CH_STRIDE + `SADF_OEN_BIT] & bit_q;
               neg_q <= enable & stat_q[c*`SADF_CH_STRIDE + `SADF_OEN_BIT] & ~bit_q;
               mid_q <= enable & stat_q[c*`SADF_CH_STRIDE + `SADF_MVOEN_BIT];
               req_q <= enable & (stat_q[c*`SADF_CH_STRIDE + `SADF_ITYPE_BIT] ?
                                  empty_w[c] : ~full_w[c]);
            end
         end

         assign pos_o[c] = pos_q;
         assign neg_o[c] = neg_q;
         assign mid_en_o[c] = mid_q;
         assign buf_req_o[c] = req_q;
      end
   endgenerate
endmodule

// ===== sadf_checker.sv
`timescale 1ns/1ps
`include "sadf_regs.vh"
module sadf_checker (
   // clock and reset
   input wire ref_clk_i,
   input wire rstn_i,
   // register bus
   input wire awvalid_i,
   input wire awready_o,
   input wire wvalid_i,
   input wire wready_o,
   input wire bvalid_o,
   input wire bready_i,
   input wire [1:0] bresp_o,
   input wire arvalid_i,
   input wire arready_o,
   input wire rvalid_o,
   input wire rready_i,
   input wire [31:0] rdata_o,
   input wire [1:0] rresp_o,
   // converter
   input wire [1:0] pos_o,
   input wire [1:0] neg_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////////////////////
   property p_b_answer;
      awvalid_i && awready_o && wvalid_i && wready_o && !bvalid_o |-> ##2 bvalid_o;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write response late");
   property p_b_stand;
      bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   property p_ready_back;
      $rose(bvalid_o) |-> awready_o && wready_o;
   endproperty
   a_ready_back: assert property (p_ready_back) else $error("write ready not back");
   property p_r_answer;
      arvalid_i && arready_o |=> rvalid_o;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read data late");
   property p_r_stand;
      rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   property p_ar_block;
      rvalid_o |-> !arready_o;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_err_zero;
      rvalid_o && rresp_o == `SADF_RESP_SLVERR |-> rdata_o == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_upper;
      rvalid_o |-> rdata_o[31:16] == 16'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_out_excl;
      (pos_o & neg_o) == 2'b00;
   endproperty
   a_out_excl: assert property (p_out_excl) else $error("both outputs high");
   c_write: cover property (bvalid_o && bready_i);
   c_err: cover property (rvalid_o && rresp_o == `SADF_RESP_SLVERR);
   c_bit: cover property ($rose(pos_o[1]));
endmodule
bind sadf_top sadf_checker u_chk (
   .ref_clk_i, .rstn_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o,
   .bready_i, .bresp_o, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .rdata_o,
   .rresp_o, .pos_o, .neg_o
);

// ===== sadf_host.sv
`timescale 1ns/1ps
module sadf_host (
   // clock
   input wire ref_clk_i,
   // requests
   output logic awvalid_o = 0,
   output logic [31:0] awaddr_o = 0,
   output logic wvalid_o = 0,
   output logic [31:0] wdata_o = 0,
   output logic bready_o = 0,
   output logic arvalid_o = 0,
   output logic [31:0] araddr_o = 0,
   output logic rready_o = 0,
   // answers
   input wire awready_i,
   input wire wready_i,
   input wire bvalid_i,
   input wire [1:0] bresp_i,
   input wire arready_i,
   input wire rvalid_i,
   input wire [31:0] rdata_i,
   input wire [1:0] rresp_i
);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input [31:0] a, input [31:0] d, output [1:0] r);
      bit aw, w;
      @(posedge ref_clk_i);
      awvalid_o <= 1;
      awaddr_o <= a;
      wvalid_o <= 1;
      wdata_o <= d;
      bready_o <= 1;
      aw = 0;
      w = 0;
      while (!(aw && w))
      begin
         @(posedge ref_clk_i);
         aw |= awvalid_o && awready_i;
         w |= wvalid_o && wready_i;
         awvalid_o <= !aw;
         wvalid_o <= !w;
      end
      while (bvalid_i !== 1'b1) @(posedge ref_clk_i);
      r = bresp_i;
      bready_o <= 0;
   endtask
   task automatic rd(input [31:0] a, output [31:0] d, output [1:0] r);
      @(posedge ref_clk_i);
      arvalid_o <= 1;
      araddr_o <= a;
      rready_o <= 1;
      do @(posedge ref_clk_i); while (arready_i !== 1'b1);
      arvalid_o <= 0;
      do @(posedge ref_clk_i); while (rvalid_i !== 1'b1);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 0;
   endtask
endmodule

// ===== stereo_audio_dac_frontend_tb.sv
`timescale 1ns/1ps
`include "sadf_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module stereo_audio_dac_frontend_tb;
   logic ref_clk_i = 0;
   logic rstn_i = 0;
   logic idle_i = 0;
   logic sleep_i = 0;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, amp;
   wire [31:0] awaddr, wdata, araddr, rdata;
   wire [1:0] bresp, rresp, pos, neg, mid, req;
   int compares = 0, n_mismatch = 0, seed = 43, n, ex;
   logic [15:0] lq[$], rq[$], sw;
   logic [31:0] d;
   logic [1:0] r;
   initial forever #25 ref_clk_i = ~ref_clk_i;
   sadf_top i_sadf_top (
      .ref_clk_i, .rstn_i, .idle_i, .sleep_i, .awvalid_i(awvalid), .awready_o(awready),
      .awaddr_i(awaddr), .awprot_i(3'h0), .wvalid_i(wvalid), .wready_o(wready),
      .wdata_i(wdata), .wstrb_i(4'hf), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
      .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .arprot_i(3'h0),
      .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .pos_o(pos),
      .neg_o(neg), .mid_en_o(mid), .buf_req_o(req), .amp_en_o(amp)
   );
   sadf_host u_host (
      .ref_clk_i, .awvalid_o(awvalid), .awaddr_o(awaddr), .wvalid_o(wvalid), .wdata_o(wdata),
      .bready_o(bready), .arvalid_o(arvalid), .araddr_o(araddr), .rready_o(rready),
      .awready_i(awready), .wready_i(wready), .bvalid_i(bvalid), .bresp_i(bresp),
      .arready_i(arready), .rvalid_i(rvalid), .rdata_i(rdata), .rresp_i(rresp)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function automatic [15:0] stat_exp();
      stat_exp = sw;
      stat_exp[9] = lq.size() == 4;
      stat_exp[8] = lq.size() == 0;
      stat_exp[1] = rq.size() == 4;
      stat_exp[0] = rq.size() == 0;
   endfunction
   task automatic wt(input int c);
      repeat (c) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic rchk(input [31:0] a, input [31:0] e);
      u_host.rd(a, d, r);
      `CHK({r, d}, {`SADF_RESP_OKAY, e})
   endtask
   task automatic push(input bit left);
      logic [15:0] v;
      v = $random(seed);
      u_host.wr(left ? `SADF_LDAT_OFS : `SADF_RDAT_OFS, {16'h0, v}, r);
      rchk(left ? `SADF_LDAT_OFS : `SADF_RDAT_OFS, {16'h0, v});
      if (left && lq.size() < 4) lq.push_back(v);
      if (!left && rq.size() < 4) rq.push_back(v);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      wt(20000);
      n_mismatch++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      rstn_i <= 1;
      rchk(`SADF_CTRL_OFS, 32'h5);
      rchk(`SADF_STAT_OFS, 32'h101);
      u_host.rd(32'h14, d, r);
      `CHK({r, d}, {`SADF_RESP_SLVERR, 32'h0})
      d = $random(seed);
      u_host.wr(`SADF_DFLT_OFS, d, r);
      rchk(`SADF_DFLT_OFS, {16'h0, d[15:0]});
      u_host.wr(`SADF_CTRL_OFS, 32'h817f, r);
      rchk(`SADF_CTRL_OFS, 32'h817f);
      sw = 16'ha4a4;
      u_host.wr(`SADF_STAT_OFS, 32'hffff, r);
      rchk(`SADF_STAT_OFS, stat_exp());
      wt(2);
      `CHK({mid, req}, 4'hf)
      // sleep holds the pop counter while filling
      sleep_i <= 1;
      for (int i = 0; i < 5; i++)
      begin
         push(1);
         rchk(`SADF_STAT_OFS, stat_exp());
      end
      push(0);
      wt(2);
      `CHK(req, 2'b00)
      sw = 16'ha0a0;
      u_host.wr(`SADF_STAT_OFS, 32'ha0a0, r);
      wt(2);
      `CHK(req, 2'b01)
      u_host.wr(`SADF_CTRL_OFS, 32'h017f, r);
      lq = {};
      rq = {};
      rchk(`SADF_STAT_OFS, stat_exp());
      wt(2);
      `CHK({amp, pos, neg}, 5'h0)
      sleep_i <= 0;
      u_host.wr(`SADF_STAT_OFS, 32'h0404, r);
      for (int dv = 0; dv < 2; dv++)
      begin
         u_host.wr(`SADF_CTRL_OFS, 32'h8000 | dv, r);
         repeat (4) push(0);
         n = 0;
         while (req[0] !== 1'b1 && n < 3000)
         begin
            wt(1);
            n++;
         end
         `CHK(n >= 700 * (dv + 1) && n <= 1040 * (dv + 1), 1'b1)
         rq = {};
      end
      `CHK({pos, neg}, 4'h0)
      u_host.wr(`SADF_CTRL_OFS, 32'h9000, r);
      sleep_i <= 1;
      push(0);
      wt(600);
      `CHK({amp, req[0]}, 2'b10)
      sleep_i <= 0;
      idle_i <= 1;
      u_host.wr(`SADF_CTRL_OFS, 32'ha000, r);
      wt(600);
      `CHK({amp, req[0]}, 2'b00)
      idle_i <= 0;
      wt(600);
      `CHK(req[0], 1'b1)
      // half-scale default through both formats, density of the positive bit
      u_host.wr(`SADF_DFLT_OFS, 32'h4000, r);
      u_host.wr(`SADF_STAT_OFS, 32'h8080, r);
      u_host.wr(`SADF_CTRL_OFS, 32'h8100, r);
      wt(600);
      for (int sg = 1; sg >= 0; sg--)
      begin
         u_host.wr(`SADF_CTRL_OFS, 32'h0000, r);
         u_host.wr(`SADF_CTRL_OFS, 32'h8000 | (sg << 8), r);
         wt(600);
         n = 0;
         repeat (512)
         begin
            wt(1);
            n += pos[1] + pos[0];
         end
         // 0x4000 is +1/2 scale signed, -1/2 scale unsigned: 3/4 or 1/4 ones
         ex = sg ? 768 : 256;
         `CHK(n > ex - 48 && n < ex + 48, 1'b1)
      end
      tally_and_finish();
   end
endmodule
